// File: hw/gsg_pkg.sv
package gsg_pkg;

  // Register byte offsets
  localparam logic [4:0] CTRL_OFS     = 5'h00;
  localparam logic [4:0] STATE_OFS    = 5'h04;
  localparam logic [4:0] INT_STAT_OFS = 5'h08;
  localparam logic [4:0] INT_MASK_OFS = 5'h0c;
  localparam logic [4:0] WORD_BASE_OFS = 5'h10;
  localparam logic [4:0] BIT_BASE_OFS = 5'h14;

  // Control register fields
  localparam int CTRL_LOCAL_GATE = 0;
  localparam int CTRL_PROJ_VALID = 1;
  localparam int CTRL_PROJ_GATE  = 2;
  localparam int CTRL_VER_MISM   = 3;
  localparam int CTRL_REPORT_SEL = 4;
  localparam int CTRL_GRIP_CLEAR = 5;
  localparam int CTRL_LAMP_LO    = 6;
  localparam int CTRL_LAMP_ASGN  = 8;
  localparam int CTRL_LEGACY     = 9;
  localparam logic [9:0] CTRL_RESET = 10'h001;

  // Interrupt bits
  localparam int IRQ_GRIP_ON  = 0;
  localparam int IRQ_GRIP_OFF = 1;
  localparam int IRQ_KEY_ON   = 2;
  localparam int IRQ_WAKE     = 3;

  // Status word placement
  localparam logic [15:0] STATUS_WORD_STEP = 16'h0004;
  localparam int          GRIP_WORD_BIT    = 4;
  localparam int          GRIP_LEGACY_BIT  = 7;

  // Debounce timing
  localparam int DEBOUNCE_US    = 1000;
  localparam int CLOCK_MHZ      = 50;
  localparam int DEBOUNCE_COUNT = DEBOUNCE_US * CLOCK_MHZ;

  // Lamp drive selection
  typedef enum logic [1:0] {
    GSG_LAMP_FOLLOWS_ENABLE     = 2'b00,
    GSG_LAMP_FOLLOWS_CONTROLLER = 2'b01,
    GSG_LAMP_DARK               = 2'b10
  } gsg_lamp_t;

endpackage : gsg_pkg

// File: hw/gsg_debounce.sv
`timescale 1ns/1ps
module gsg_debounce #(
  parameter int COUNT = gsg_pkg::DEBOUNCE_COUNT
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Raw and clean level
  input  wire logic rawIn,
  output logic      cleanOut
);
  import gsg_pkg::*;

  logic        syncAReg;
  logic        syncBReg;
  logic [15:0] cntReg;
  localparam logic [15:0] CNT_LAST = 16'(COUNT - 1);

  // Two-stage synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      syncAReg <= 1'b0;
      syncBReg <= 1'b0;
    end else begin
      syncAReg <= rawIn;
      syncBReg <= syncAReg;
    end
  end

  // Accept a new level only after it stays stable
  always_ff @(posedge clock) begin
    if (rst) begin
      cntReg   <= 16'h0000;
      cleanOut <= 1'b0;
    end else if (syncBReg == cleanOut) begin
      cntReg <= 16'h0000;
    end else if (cntReg == CNT_LAST) begin
      cntReg   <= 16'h0000;
      cleanOut <= syncBReg;
    end else begin
      cntReg <= cntReg + 16'h0001;
    end
  end

endmodule : gsg_debounce

// File: hw/gsg_grip_gating.sv
`timescale 1ns/1ps
module gsg_grip_gating #(
  parameter int DEBOUNCE_CYCLES = gsg_pkg::DEBOUNCE_COUNT
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // Grip switch pin
  input  wire logic        gripPin,
  // Touch panel side
  input  wire logic        touchPress,
  input  wire logic        onSystemScreen,
  input  wire logic        saverActive,
  output logic             touchAccept,
  output logic             keyOnPulse,
  output logic             keyTarget,
  output logic             saverWake,
  // Front lamp
  output logic             enableLamp,
  // Controller link
  input  wire logic        lampCtrlBit,
  output logic             linkWrite,
  output logic             linkLegacy,
  output logic [15:0]      linkAddr,
  output logic [15:0]      linkData,
  // Interrupt
  output logic             irq
);
  import gsg_pkg::*;

  // Byte-lane merge for register writes
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal,
                                            input logic [31:0] newVal,
                                            input logic [3:0]  be);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = newVal[8*i +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  logic        gripClean;
  logic        gripPrevReg;
  logic        ackReg;
  logic        busWr;
  logic [9:0]  ctrlReg;
  logic [3:0]  intStatReg;
  logic [3:0]  intMaskReg;
  logic [15:0] wordBaseReg;
  logic [15:0] bitBaseReg;
  logic        touchPrevReg;
  logic        reportPrevReg;
  logic        gateEff;
  logic        reportEn;
  logic        allowTouch;
  logic        gripRise;
  logic        gripFall;
  logic        pressEdge;
  logic [3:0]  events;
  logic [31:0] ctrlMerged;
  gsg_lamp_t   lampSel;

  // Grip debounce
  gsg_debounce #(
    .COUNT (DEBOUNCE_CYCLES)
  ) uDebounce (
    .clock    (clock),
    .rst      (rst),
    .rawIn    (gripPin),
    .cleanOut (gripClean)
  );

  // Grip edge history
  always_ff @(posedge clock) begin
    if (rst) begin
      gripPrevReg <= 1'b0;
    end else begin
      gripPrevReg <= gripClean;
    end
  end

  assign gripRise = gripClean & ~gripPrevReg;
  assign gripFall = ~gripClean & gripPrevReg;

  // Effective gating and reporting
  always_comb begin
    if (ctrlReg[CTRL_VER_MISM]) begin
      gateEff = 1'b1;
    end else if (ctrlReg[CTRL_PROJ_VALID]) begin
      gateEff = ctrlReg[CTRL_PROJ_GATE];
    end else begin
      gateEff = ctrlReg[CTRL_LOCAL_GATE];
    end
  end

  assign reportEn = gateEff | ctrlReg[CTRL_REPORT_SEL];
  assign lampSel  = gsg_lamp_t'(ctrlReg[CTRL_LAMP_LO +: 2]);

  // Touch permission
  assign allowTouch = onSystemScreen | ~gateEff | gripClean;
  assign pressEdge  = touchPress & ~touchPrevReg;

  // Touch acceptance and on-action
  always_ff @(posedge clock) begin
    if (rst) begin
      touchPrevReg <= 1'b0;
      touchAccept  <= 1'b0;
      keyOnPulse   <= 1'b0;
    end else begin
      touchPrevReg <= touchPress;
      touchAccept  <= touchPress & allowTouch;
      keyOnPulse   <= pressEdge & allowTouch;
    end
  end

  // Momentary target bit
  always_ff @(posedge clock) begin
    if (rst) begin
      keyTarget <= 1'b0;
    end else if (pressEdge & allowTouch) begin
      keyTarget <= 1'b1;
    end else if (~touchPress) begin
      keyTarget <= 1'b0;
    end else if (ctrlReg[CTRL_GRIP_CLEAR] & gripFall & gateEff & ~onSystemScreen) begin
      keyTarget <= 1'b0;
    end
  end

  // Screen saver wake
  always_ff @(posedge clock) begin
    if (rst) begin
      saverWake <= 1'b0;
    end else begin
      saverWake <= gripRise & saverActive;
    end
  end

  // Lamp drive
  always_ff @(posedge clock) begin
    if (rst) begin
      enableLamp <= 1'b0;
    end else begin
      unique case (lampSel)
        GSG_LAMP_FOLLOWS_ENABLE: begin
          enableLamp <= gripClean;
        end
        GSG_LAMP_FOLLOWS_CONTROLLER: begin
          enableLamp <= lampCtrlBit & ctrlReg[CTRL_LAMP_ASGN];
        end
        GSG_LAMP_DARK: begin
          enableLamp <= 1'b0;
        end
        default: begin
          enableLamp <= 1'b0;
        end
      endcase
    end
  end

  // Grip report to the controller
  always_ff @(posedge clock) begin
    if (rst) begin
      reportPrevReg <= 1'b0;
      linkWrite     <= 1'b0;
      linkLegacy    <= 1'b0;
      linkAddr      <= 16'h0000;
      linkData      <= 16'h0000;
    end else begin
      reportPrevReg <= reportEn;
      linkWrite     <= reportEn & ((gripClean ^ gripPrevReg) | ~reportPrevReg);
      linkLegacy    <= ctrlReg[CTRL_LEGACY];
      linkData      <= 16'h0000;
      if (ctrlReg[CTRL_LEGACY]) begin
        linkAddr                  <= bitBaseReg;
        linkData[GRIP_LEGACY_BIT] <= gripClean;
      end else begin
        linkAddr                <= wordBaseReg + STATUS_WORD_STEP;
        linkData[GRIP_WORD_BIT] <= gripClean;
      end
    end
  end

  // Bus handshake: one wait state per access
  always_ff @(posedge clock) begin
    if (rst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= (read | write) & ~ackReg;
    end
  end

  assign waitrequest = (read | write) & ~ackReg;
  assign busWr       = write & ackReg;
  assign ctrlMerged  = laneMerge({22'h000000, ctrlReg}, writedata, byteenable);

  // Control register
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrlReg <= CTRL_RESET;
    end else if (busWr && address == CTRL_OFS) begin
      ctrlReg <= ctrlMerged[9:0];
    end
  end

  // Base registers for the controller link
  always_ff @(posedge clock) begin
    if (rst) begin
      wordBaseReg <= 16'h0000;
      bitBaseReg  <= 16'h0000;
    end else if (busWr && address == WORD_BASE_OFS) begin
      wordBaseReg <= 16'(laneMerge({16'h0000, wordBaseReg}, writedata, byteenable));
    end else if (busWr && address == BIT_BASE_OFS) begin
      bitBaseReg <= 16'(laneMerge({16'h0000, bitBaseReg}, writedata, byteenable));
    end
  end

  // Interrupt events, set wins over clear
  assign events = {saverWake, keyOnPulse, gripFall, gripRise};

  always_ff @(posedge clock) begin
    if (rst) begin
      intStatReg <= 4'h0;
    end else if (busWr && address == INT_STAT_OFS && byteenable[0]) begin
      intStatReg <= (intStatReg & ~writedata[3:0]) | events;
    end else begin
      intStatReg <= intStatReg | events;
    end
  end

  // Interrupt mask
  always_ff @(posedge clock) begin
    if (rst) begin
      intMaskReg <= 4'h0;
    end else if (busWr && address == INT_MASK_OFS && byteenable[0]) begin
      intMaskReg <= writedata[3:0];
    end
  end

  assign irq = |(intStatReg & intMaskReg);

  // Read data, captured on the first request cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (read & ~ackReg) begin
      unique case (address)
        CTRL_OFS:      readdata <= {22'h000000, ctrlReg};
        STATE_OFS:     readdata <= {26'h0000000, touchAccept, keyTarget, enableLamp,
                                    reportEn, gateEff, gripClean};
        INT_STAT_OFS:  readdata <= {28'h0000000, intStatReg};
        INT_MASK_OFS:  readdata <= {28'h0000000, intMaskReg};
        WORD_BASE_OFS: readdata <= {16'h0000, wordBaseReg};
        BIT_BASE_OFS:  readdata <= {16'h0000, bitBaseReg};
        default:       readdata <= 32'h00000000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence seqGateOnReleased;
    gateEff && !gripClean && !onSystemScreen && touchPress;
  endsequence

  sequence seqKeyHeldGripDrop;
    ctrlReg[CTRL_GRIP_CLEAR] && gateEff && !onSystemScreen && touchPress
      && !pressEdge && gripFall;
  endsequence

  AST_RESET_GATE_ON: assert property (
    $fell(rst) |-> ctrlReg[CTRL_LOCAL_GATE] && !ctrlReg[CTRL_PROJ_VALID])
    else $error("gating not enabled after reset");

  AST_REJECT_RELEASED: assert property (
    seqGateOnReleased |=> !touchAccept)
    else $error("touch accepted with grip released");

  AST_SYSTEM_SCREEN: assert property (
    onSystemScreen && touchPress |=> touchAccept)
    else $error("system screen touch rejected");

  AST_UNGATED: assert property (
    !gateEff && touchPress |=> touchAccept)
    else $error("ungated touch rejected");

  AST_GRIP_ALLOWS: assert property (
    gripClean && touchPress |=> touchAccept)
    else $error("touch rejected while grip held");

  AST_MISMATCH_FORCE: assert property (
    ctrlReg[CTRL_VER_MISM] |-> gateEff && reportEn)
    else $error("mismatch did not force gating");

  AST_KEY_ON: assert property (
    pressEdge && allowTouch |=> keyOnPulse && keyTarget)
    else $error("on-action missing");

  AST_KEY_RELEASE: assert property (
    keyTarget && !touchPress && !pressEdge |=> !keyTarget)
    else $error("target bit kept after key release");

  AST_GRIP_CLEAR: assert property (
    seqKeyHeldGripDrop |=> !keyTarget)
    else $error("target bit kept after grip drop");

  AST_WAKE: assert property (
    gripRise && saverActive |=> saverWake)
    else $error("saver not woken");

  AST_LAMP_DARK: assert property (
    lampSel == GSG_LAMP_DARK |=> !enableLamp)
    else $error("lamp lit while dark selected");

  AST_WORD_REPORT: assert property (
    linkWrite && !linkLegacy && $stable(wordBaseReg)
      |-> linkAddr == wordBaseReg + STATUS_WORD_STEP
          && linkData[GRIP_WORD_BIT] == $past(gripClean))
    else $error("status word report wrong");

  AST_LEGACY_REPORT: assert property (
    linkWrite && linkLegacy |-> linkData[GRIP_LEGACY_BIT] == $past(gripClean)
      && linkData[GRIP_WORD_BIT] == 1'b0)
    else $error("legacy bit report wrong");

  AST_REPORT_ON_CHANGE: assert property (
    reportEn && $past(reportEn) && (gripClean != gripPrevReg) |=> linkWrite)
    else $error("grip change not reported");

  AST_BUS_ONE_WAIT: assert property (
    (read || write) && waitrequest && $stable(address) |=> !waitrequest)
    else $error("bus answer late");

endmodule : gsg_grip_gating

// File: dv/gsg_plc_model.sv
`timescale 1ns/1ps
// Controller side of the status link: stores status words, drives the lamp bit
module gsg_plc_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Status link from the terminal
  input  wire logic        linkWrite,
  input  wire logic        linkLegacy,
  input  wire logic [15:0] linkAddr,
  input  wire logic [15:0] linkData,
  // Lamp device bit from the controller program
  input  wire logic        lampSet,
  output logic             lampCtrlBit,
  // Last status write seen
  output logic [15:0]      lastAddr,
  output logic [15:0]      lastData,
  output logic             lastLegacy,
  output logic [7:0]       writeCount
);
  logic        lampBit_reg;
  logic [15:0] addr_reg;
  logic [15:0] data_reg;
  logic        legacy_reg;
  logic [7:0]  count_reg;

  // Capture each status word in the cycle it is written
  always_ff @(posedge clock) begin
    if (rst) begin
      addr_reg   <= 16'h0000;
      data_reg   <= 16'h0000;
      legacy_reg <= 1'b0;
      count_reg  <= 8'h00;
    end else if (linkWrite) begin
      addr_reg   <= linkAddr;
      data_reg   <= linkData;
      legacy_reg <= linkLegacy;
      count_reg  <= count_reg + 8'h01;
    end
  end

  // Lamp bit follows the program one cycle later
  always_ff @(posedge clock) begin
    lampBit_reg <= rst ? 1'b0 : lampSet;
  end

  // Outputs
  assign lampCtrlBit = lampBit_reg;
  assign lastAddr    = addr_reg;
  assign lastData    = data_reg;
  assign lastLegacy  = legacy_reg;
  assign writeCount  = count_reg;
endmodule : gsg_plc_model

// File: dv/gsg_grip_gating_tb_top.sv
`timescale 1ns/1ps
module gsg_grip_gating_tb_top;
  import gsg_pkg::*;
  logic        clock, rst, read, write, waitrequest, gripPin, touchPress, onSystemScreen;
  logic        saverActive, touchAccept, keyOnPulse, keyTarget, saverWake, enableLamp;
  logic        lampCtrlBit, linkWrite, linkLegacy, irq, lampSet, lastLegacy;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, d;
  logic [15:0] linkAddr, linkData, lastAddr, lastData;
  logic [7:0]  writeCount, n0;
  int          errTotal, totalChecks, nKey, nWake;

  gsg_grip_gating #(.DEBOUNCE_CYCLES(4)) dut (
    .clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .gripPin(gripPin), .touchPress(touchPress),
    .onSystemScreen(onSystemScreen), .saverActive(saverActive), .touchAccept(touchAccept),
    .keyOnPulse(keyOnPulse), .keyTarget(keyTarget), .saverWake(saverWake),
    .enableLamp(enableLamp), .lampCtrlBit(lampCtrlBit), .linkWrite(linkWrite),
    .linkLegacy(linkLegacy), .linkAddr(linkAddr), .linkData(linkData), .irq(irq));

  gsg_plc_model plc (
    .clock(clock), .rst(rst), .linkWrite(linkWrite), .linkLegacy(linkLegacy),
    .linkAddr(linkAddr), .linkData(linkData), .lampSet(lampSet), .lampCtrlBit(lampCtrlBit),
    .lastAddr(lastAddr), .lastData(lastData), .lastLegacy(lastLegacy),
    .writeCount(writeCount));

  // Clock
  always #10 clock = ~clock;

  // Count one-cycle pulses
  always @(posedge clock) begin
    if (rst === 1'b0 && keyOnPulse === 1'b1) nKey++;
    if (rst === 1'b0 && saverWake === 1'b1) nWake++;
  end

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task finishTest;
    if (errTotal == 0 && totalChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finishTest

  // Hold request to the rising edge that sees waitrequest low, take data there, then release
  task busAcc(input logic wr, input logic [4:0] a, input logic [31:0] v);
    address   <= a;
    writedata <= v;
    write     <= wr;
    read      <= ~wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    d = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    @(posedge clock);
  endtask : busAcc

  // Debounce plus sync settles well inside twelve cycles
  task setGrip(input logic v);
    gripPin <= v;
    repeat (12) @(posedge clock);
  endtask : setGrip

  task touch(input logic v);
    touchPress <= v;
    repeat (3) @(posedge clock);
  endtask : touch

  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    $display("MISMATCH watchdog expected done seen hang");
    errTotal++;
    finishTest();
  end

  // Main sequence
  initial begin
    clock = 0; rst = 1; address = 0; read = 0; write = 0; byteenable = 4'hf;
    writedata = 0; gripPin = 0; touchPress = 0; onSystemScreen = 0; saverActive = 0;
    lampSet = 0; errTotal = 0; totalChecks = 0; nKey = 0; nWake = 0;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    busAcc(1'b0, CTRL_OFS, 32'h0); chk("ctrl reset", d, 32'h0000_0001);
    busAcc(1'b0, 5'h18, 32'h0); chk("unmapped read", d, 32'h0);
    busAcc(1'b1, WORD_BASE_OFS, 32'h0000_0020);
    busAcc(1'b1, BIT_BASE_OFS, 32'h0000_0100);
    busAcc(1'b1, INT_MASK_OFS, 32'h0000_0001);
    // User screen with grip released, then a system screen
    touch(1'b1); chk("accept released", touchAccept, 1'b0);
    chk("no key pulse", nKey, 0);
    onSystemScreen <= 1'b1;
    repeat (3) @(posedge clock);
    chk("accept system", touchAccept, 1'b1);
    touch(1'b0);
    onSystemScreen <= 1'b0;
    // Grip press while blanked
    saverActive <= 1'b1;
    setGrip(1'b1); chk("wake", nWake, 1);
    chk("word addr", lastAddr, 16'h0024);
    chk("word bit4", lastData[4], 1'b1);
    chk("lamp grip", enableLamp, 1'b1);
    chk("irq raised", irq, 1'b1);
    busAcc(1'b0, STATE_OFS, 32'h0); chk("state", d, 32'h0000_000f);
    busAcc(1'b1, INT_STAT_OFS, 32'h0000_000f); chk("irq cleared", irq, 1'b0);
    saverActive <= 1'b0;
    // Key-release clears mode
    touch(1'b1); chk("key on", nKey, 1);
    setGrip(1'b0); chk("target held", keyTarget, 1'b1);
    chk("word bit4 off", lastData[4], 1'b0);
    chk("irq masked", irq, 1'b0);
    busAcc(1'b0, INT_STAT_OFS, 32'h0); chk("release status", d[1], 1'b1);
    touch(1'b0); chk("target key off", keyTarget, 1'b0);
    // Grip-release clears mode
    busAcc(1'b1, CTRL_OFS, 32'h0000_0021);
    setGrip(1'b1); touch(1'b1); chk("key on again", nKey, 2);
    chk("no wake", nWake, 1);
    setGrip(1'b0); chk("target grip off", keyTarget, 1'b0);
    touch(1'b0);
    // Short glitch must not reach the link
    n0 = writeCount;
    gripPin <= 1'b1;
    repeat (2) @(posedge clock);
    setGrip(1'b0); chk("glitch", writeCount, n0);
    // Gating off, reporting selectable
    busAcc(1'b1, CTRL_OFS, 32'h0);
    touch(1'b1); chk("accept ungated", touchAccept, 1'b1);
    touch(1'b0);
    n0 = writeCount;
    setGrip(1'b1); setGrip(1'b0); chk("no report", writeCount, n0);
    busAcc(1'b1, CTRL_OFS, 32'h0000_0010);
    setGrip(1'b1); chk("report on", lastData[4], 1'b1);
    setGrip(1'b0);
    // Project override and version mismatch
    busAcc(1'b1, CTRL_OFS, 32'h0000_0003);
    touch(1'b1); chk("project override", touchAccept, 1'b1);
    touch(1'b0);
    busAcc(1'b1, CTRL_OFS, 32'h0000_0008);
    touch(1'b1); chk("mismatch gated", touchAccept, 1'b0);
    touch(1'b0);
    // Lamp from controller bit, then dark
    busAcc(1'b1, CTRL_OFS, 32'h0000_0141);
    lampSet <= 1'b1;
    repeat (4) @(posedge clock);
    chk("lamp ctrl on", enableLamp, 1'b1);
    busAcc(1'b1, CTRL_OFS, 32'h0000_0041);
    @(posedge clock);
    chk("lamp unassigned", enableLamp, 1'b0);
    lampSet <= 1'b0;
    busAcc(1'b1, CTRL_OFS, 32'h0000_0141);
    repeat (4) @(posedge clock);
    chk("lamp ctrl off", enableLamp, 1'b0);
    setGrip(1'b1); chk("lamp not grip", enableLamp, 1'b0);
    lampSet <= 1'b1;
    busAcc(1'b1, CTRL_OFS, 32'h0000_0081);
    @(posedge clock);
    chk("lamp dark", enableLamp, 1'b0);
    // Legacy bit-block mapping
    busAcc(1'b1, CTRL_OFS, 32'h0000_0201);
    setGrip(1'b0); chk("legacy flag", lastLegacy, 1'b1);
    chk("legacy addr", lastAddr, 16'h0100);
    chk("legacy bit7 off", lastData[7], 1'b0);
    setGrip(1'b1); chk("legacy bit7 on", lastData[7], 1'b1);
    finishTest();
  end
endmodule : gsg_grip_gating_tb_top
